// file: cmd_fetch_defines.vh
// constants, register map and field layout of the command fetch engine
//
// Behaviour
// RULE1 - move 8-byte units to buffer, bump current pointer, stop at end pointer
// RULE2 - start and end pointers have pending copies, written without disturbing a fetch
// RULE3 - start write sets start-valid flag, end write sets end-valid flag
// RULE4 - pending pointers are taken only once the running transfer has finished; code takes them between words, also before current reaches end
// RULE5 - taking a new start pointer loads current pointer with it
// RULE6 - own read path reads data memory or dram per source select
// RULE7 - producer sets start and end equal, then stores commands from start
// RULE8 - producer advances end pointer only past whole stored commands
// RULE9 - producer waits for start-valid flag clear before wrapping its ring
// RULE10 - producer waits current pointer off base, then writes base to start
// RULE11 - producer waits current pointer outside region it is about to write
// RULE12 - producer sets data-memory source first, then start and end alike
// RULE13 - status shows start-valid bit 10, end-valid bit 9, source bit 0
// RULE14 - status write bit 0 clears source select, bit 1 sets it
// RULE15 - current pointer read only; pointers are 24-bit dram or 12-bit memory
// RULE16 - with current equal end and nothing pending, no reads are issued
// RULE17 - taking a pending pointer clears its valid flag
`ifndef CMD_FETCH_DEFINES_VH
`define CMD_FETCH_DEFINES_VH

// ----------------------------------------
// register byte addresses
// ----------------------------------------
`define REG_START    5'h00
`define REG_END      5'h04
`define REG_CURRENT  5'h08
`define REG_STATUS   5'h0c

// ----------------------------------------
// widths
// ----------------------------------------
`define PTR_W        24
`define SP_DATA_MEMORY_PTR_W   12
`define WORD_W       64
`define UNIT_BYTES   24'h000008

// ----------------------------------------
// status fields and fifo size
// ----------------------------------------
`define ST_SRC       0
`define ST_SRC_SET   1
`define ST_BUSY      8
`define ST_EV        9
`define ST_SV        10
`define FIFO_DEPTH   4
`define FIFO_AW      2

`endif

// file: cmd_fifo.v
// small synchronous fifo for fetched command words
`timescale 1ns/1ns
module cmd_fifo #(
  parameter WIDTH = 64,
  parameter DEPTH = 4,
  parameter AW    = 2
) (
  // clock and reset
  input  wire             clk,
  input  wire             rst,
  // fill side
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  // drain side
  output wire             out_valid,
  input  wire             out_ready,
  output reg  [WIDTH-1:0] out_data
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr;
  reg [AW-1:0]    rd_ptr;
  reg [AW:0]      count;
  reg             out_full;

  wire push;
  wire pop;
  wire load;

  // output register holds head word; storage behind it
  assign out_valid = out_full;
  assign load      = (count != {(AW+1){1'b0}}) && (!out_full || out_ready);
  assign pop       = out_full && out_ready;
  assign in_ready  = (count != DEPTH[AW:0]);
  assign push      = in_valid && in_ready;

  always @(posedge clk) begin
    if (rst) begin
      wr_ptr   <= {AW{1'b0}};
      rd_ptr   <= {AW{1'b0}};
      count    <= {(AW+1){1'b0}};
      out_full <= 1'b0;
      out_data <= {WIDTH{1'b0}};
    end else begin
      if (push) begin
        mem[wr_ptr] <= in_data;
        wr_ptr      <= wr_ptr + 1'b1;
      end
      if (load) begin
        out_data <= mem[rd_ptr];
        rd_ptr   <= rd_ptr + 1'b1;
        out_full <= 1'b1;
      end else if (pop) begin
        out_full <= 1'b0;
      end
      if (push && !load)
        count <= count + 1'b1;
      else if (load && !push)
        count <= count - 1'b1;
    end
  end

endmodule // cmd_fifo

// file: display_command_fetch.v
// command fetch engine: wishbone registers, memory read path, command fifo
//
// Design decisions made here: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/1ns
`include "cmd_fetch_defines.vh"
module display_command_fetch (
  // clock and reset
  input  wire                clk,
  input  wire                rst,
  // wishbone slave
  input  wire                wb_cyc_i,
  input  wire                wb_stb_i,
  input  wire                wb_we_i,
  input  wire [4:0]          wb_adr_i,
  input  wire [3:0]          wb_sel_i,
  input  wire [31:0]         wb_dat_i,
  output reg  [31:0]         wb_dat_o,
  output reg                 wb_ack_o,
  // data memory read port (direct_mem_path)
  output reg                 sp_data_memory_rd_req,
  output reg  [11:0]         sp_data_memory_rd_addr,
  input  wire                sp_data_memory_rd_ack,
  input  wire [63:0]         sp_data_memory_rd_data,
  // dram read port
  output reg                 dram_rd_req,
  output reg  [23:0]         dram_rd_addr,
  input  wire                dram_rd_ack,
  input  wire [63:0]         dram_rd_data,
  // command buffer output
  output wire                cmd_valid,
  input  wire                cmd_ready,
  output wire [63:0]         cmd_data
);

  // ----------------------------------------
  // states
  // ----------------------------------------
  localparam ST_IDLE = 3'b001;
  localparam ST_READ = 3'b010;
  localparam ST_PUSH = 3'b100;

  reg [2:0]            state;
  reg [`PTR_W-1:0]     start_pend;
  reg [`PTR_W-1:0]     end_pend;
  reg [`PTR_W-1:0]     end_act;
  reg [`PTR_W-1:0]     current;
  reg                  start_valid;
  reg                  end_valid;
  reg                  src_sp_data_memory;
  reg [`WORD_W-1:0]    word;

  wire                 fifo_in_ready;
  wire                 wr_stb;
  wire                 rd_stb;
  wire                 wr_start;
  wire                 wr_end;
  wire                 wr_status;
  wire                 take;
  wire                 rd_ack;
  wire [`PTR_W-1:0]    cur_mask;
  wire [`PTR_W-1:0]    end_mask;
  wire [`PTR_W-1:0]    next_cur;
  wire [31:0]          status_word;

  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  assign wr_stb    = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
  assign rd_stb    = wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o;
  assign wr_start  = wr_stb && (wb_adr_i == `REG_START);
  assign wr_end    = wr_stb && (wb_adr_i == `REG_END);
  assign wr_status = wr_stb && (wb_adr_i == `REG_STATUS) && wb_sel_i[0];

  // source width of pointers
  assign cur_mask  = src_sp_data_memory ? {{(`PTR_W-`SP_DATA_MEMORY_PTR_W){1'b0}}, current[`SP_DATA_MEMORY_PTR_W-1:0]} : current; // RULE15
  assign end_mask  = src_sp_data_memory ? {{(`PTR_W-`SP_DATA_MEMORY_PTR_W){1'b0}}, end_act[`SP_DATA_MEMORY_PTR_W-1:0]} : end_act; // RULE15
  assign next_cur  = current + `UNIT_BYTES; // RULE1

  // adopt pending pointers only between words; a lone start waits for its end
  assign take      = (state == ST_IDLE) && end_valid; // RULE4
  assign rd_ack    = src_sp_data_memory ? sp_data_memory_rd_ack : dram_rd_ack;

  assign status_word = {21'h000000, start_valid, end_valid, (state != ST_IDLE),
                        7'h00, src_sp_data_memory}; // RULE13

  // ----------------------------------------
  // register slave
  // ----------------------------------------
  always @(posedge clk) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= wr_stb || rd_stb;
      if (rd_stb) begin
        case (wb_adr_i)
          `REG_START:   wb_dat_o <= {8'h00, start_pend};
          `REG_END:     wb_dat_o <= {8'h00, end_pend};
          `REG_CURRENT: wb_dat_o <= {8'h00, current}; // RULE15
          `REG_STATUS:  wb_dat_o <= status_word;
          default:      wb_dat_o <= 32'h00000000;
        endcase
      end
    end
  end

  // pending copies and their flags; a write wins over adoption
  always @(posedge clk) begin
    if (rst) begin
      start_pend  <= {`PTR_W{1'b0}};
      end_pend    <= {`PTR_W{1'b0}};
      start_valid <= 1'b0;
      end_valid   <= 1'b0;
      src_sp_data_memory    <= 1'b0;
    end else begin
      if (wr_start) begin
        start_pend  <= wb_dat_i[`PTR_W-1:0]; // RULE2
        start_valid <= 1'b1; // RULE3
      end else if (take) begin
        start_valid <= 1'b0; // RULE17
      end
      if (wr_end) begin
        end_pend  <= wb_dat_i[`PTR_W-1:0]; // RULE2
        end_valid <= 1'b1; // RULE3
      end else if (take) begin
        end_valid <= 1'b0; // RULE17
      end
      if (wr_status && wb_dat_i[`ST_SRC_SET])
        src_sp_data_memory <= 1'b1; // RULE14
      else if (wr_status && wb_dat_i[`ST_SRC])
        src_sp_data_memory <= 1'b0; // RULE14
    end
  end

  // ----------------------------------------
  // fetch engine
  // ----------------------------------------
  always @(posedge clk) begin
    if (rst) begin
      state        <= ST_IDLE;
      current      <= {`PTR_W{1'b0}};
      end_act      <= {`PTR_W{1'b0}};
      word         <= {`WORD_W{1'b0}};
      sp_data_memory_rd_req  <= 1'b0;
      sp_data_memory_rd_addr <= 12'h000;
      dram_rd_req  <= 1'b0;
      dram_rd_addr <= 24'h000000;
    end else begin
      case (state)
        ST_IDLE: begin
          if (take) begin
            if (start_valid)
              current <= start_pend; // RULE5
            if (end_valid)
              end_act <= end_pend; // RULE4
          end else if (cur_mask != end_mask) begin
            state        <= ST_READ; // RULE16
            sp_data_memory_rd_req  <= src_sp_data_memory; // RULE6
            dram_rd_req  <= !src_sp_data_memory; // RULE6
            sp_data_memory_rd_addr <= {current[`SP_DATA_MEMORY_PTR_W-1:3], 3'b000};
            dram_rd_addr <= {current[`PTR_W-1:3], 3'b000};
          end
        end
        ST_READ: begin
          if (rd_ack) begin
            sp_data_memory_rd_req <= 1'b0;
            dram_rd_req <= 1'b0;
            word        <= src_sp_data_memory ? sp_data_memory_rd_data : dram_rd_data; // RULE6
            state       <= ST_PUSH;
          end
        end
        ST_PUSH: begin
          if (fifo_in_ready) begin
            current <= next_cur; // RULE1
            state   <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // command buffer
  // ----------------------------------------
  cmd_fifo #(
    .WIDTH (`WORD_W),
    .DEPTH (`FIFO_DEPTH),
    .AW    (`FIFO_AW)
  ) u_fifo (
    .clk       (clk),
    .rst       (rst),
    .in_valid  (state == ST_PUSH),
    .in_ready  (fifo_in_ready),
    .in_data   (word),
    .out_valid (cmd_valid),
    .out_ready (cmd_ready),
    .out_data  (cmd_data)
  );

endmodule // display_command_fetch

// file: cmd_mem_model.sv
// read-port model of data memory or dram feeding the fetch engine
`timescale 1ns/1ns
module cmd_mem_model #(
  parameter W = 24,
  parameter D = 0
) (
  input  wire         clk,
  input  wire         req,
  input  wire [W-1:0] addr,
  output reg          ack,
  output reg  [63:0]  data
);
  reg [3:0] n;
  initial begin
    ack = 1'b0;
    n = 4'h0;
    data = 64'h0;
  end
  // answer after D wait cycles, data is the requested byte address
  always @(posedge clk) begin
    n <= (req && !ack) ? n + 4'h1 : 4'h0;
    ack <= req && !ack && n == D;
    data <= (req && !ack && n == D) ? {{(64-W){1'b0}}, addr} : ~data;
  end
endmodule // cmd_mem_model

// file: display_command_fetch_properties.sv
// port assertions of the command fetch engine
`timescale 1ns/1ns
module display_command_fetch_checker (
  input wire        clk,
  input wire        rst,
  input wire        wb_cyc_i,
  input wire        wb_stb_i,
  input wire        wb_ack_o,
  input wire        sp_data_memory_rd_req,
  input wire [11:0] sp_data_memory_rd_addr,
  input wire        sp_data_memory_rd_ack,
  input wire        dram_rd_req,
  input wire [23:0] dram_rd_addr,
  input wire        dram_rd_ack,
  input wire        cmd_valid,
  input wire        cmd_ready,
  input wire [63:0] cmd_data
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  property p_ack_next; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  a_ack_next: assert property (p_ack_next) else $error("bus ack late");
  property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("bus ack too long");
  property p_dram_hold; dram_rd_req && !dram_rd_ack |=> dram_rd_req && $stable(dram_rd_addr); endproperty
  a_dram_hold: assert property (p_dram_hold) else $error("dram request not held");
  property p_dram_drop; dram_rd_ack |=> !dram_rd_req [*2]; endproperty
  a_dram_drop: assert property (p_dram_drop) else $error("dram request too soon");
  property p_sp_data_memory_hold; sp_data_memory_rd_req && !sp_data_memory_rd_ack |=> sp_data_memory_rd_req && $stable(sp_data_memory_rd_addr); endproperty
  a_sp_data_memory_hold: assert property (p_sp_data_memory_hold) else $error("memory request not held");
  property p_sp_data_memory_drop; sp_data_memory_rd_ack |=> !sp_data_memory_rd_req [*2]; endproperty
  a_sp_data_memory_drop: assert property (p_sp_data_memory_drop) else $error("memory request too soon");
  property p_one_src; !(dram_rd_req && sp_data_memory_rd_req); endproperty
  a_one_src: assert property (p_one_src) else $error("both sources read");
  property p_align; dram_rd_req |-> dram_rd_addr[2:0] == 3'h0; endproperty
  a_align: assert property (p_align) else $error("unit not aligned");
  property p_cmd_hold; cmd_valid && !cmd_ready |=> cmd_valid && $stable(cmd_data); endproperty
  a_cmd_hold: assert property (p_cmd_hold) else $error("command word dropped");
endmodule // display_command_fetch_checker
bind display_command_fetch display_command_fetch_checker chk_u (.clk(clk), .rst(rst), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .sp_data_memory_rd_req(sp_data_memory_rd_req), .sp_data_memory_rd_addr(sp_data_memory_rd_addr),
  .sp_data_memory_rd_ack(sp_data_memory_rd_ack), .dram_rd_req(dram_rd_req), .dram_rd_addr(dram_rd_addr), .dram_rd_ack(dram_rd_ack),
  .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_data(cmd_data));

// file: test_display_command_fetch.sv
// bench for the command fetch engine
`timescale 1ns/1ns
module test_display_command_fetch;
  reg         clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, cmd_ready = 1, src = 0;
  reg  [4:0]  adr = 5'h00;
  reg  [31:0] dat = 32'h0, rdata;
  wire [31:0] wb_dat_o;
  wire        wb_ack_o, sp_data_memory_rd_req, sp_data_memory_rd_ack, dram_rd_req, dram_rd_ack, cmd_valid;
  wire [11:0] sp_data_memory_rd_addr;
  wire [23:0] dram_rd_addr;
  wire [63:0] sp_data_memory_rd_data, dram_rd_data, cmd_data;
  int         miscompares = 0, total_checks = 0, cycles = 0, n;
  display_command_fetch dut_u (.clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .sp_data_memory_rd_req(sp_data_memory_rd_req), .sp_data_memory_rd_addr(sp_data_memory_rd_addr), .sp_data_memory_rd_ack(sp_data_memory_rd_ack),
    .sp_data_memory_rd_data(sp_data_memory_rd_data), .dram_rd_req(dram_rd_req), .dram_rd_addr(dram_rd_addr),
    .dram_rd_ack(dram_rd_ack), .dram_rd_data(dram_rd_data), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_data(cmd_data));
  cmd_mem_model #(.W(24), .D(3)) dram_u (.clk(clk), .req(dram_rd_req), .addr(dram_rd_addr),
    .ack(dram_rd_ack), .data(dram_rd_data));
  cmd_mem_model #(.W(12), .D(0)) sp_data_memory_u (.clk(clk), .req(sp_data_memory_rd_req), .addr(sp_data_memory_rd_addr),
    .ack(sp_data_memory_rd_ack), .data(sp_data_memory_rd_data));
  always #4 clk = ~clk;
  task results;
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      results;
    end
  end
  task chk(input string s, input [63:0] g, input [63:0] e);
    total_checks++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", s, e, g);
    end
  endtask
  task wb(input w, input [4:0] a, input [31:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    @(posedge clk);
    while (wb_ack_o !== 1'b1) @(posedge clk);
    rdata = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task rd(input [4:0] a, input [31:0] e);
    wb(1'b0, a, 32'h0);
    chk("register", rdata, e);
  endtask
  task drain(input [23:0] b);
    int idle;
    reg [23:0] a;
    idle = 0;
    n = 0;
    @(posedge clk);
    cmd_ready <= 1'b1;
    while (idle < 40) begin
      @(negedge clk);
      a = b + 24'(n * 8);
      if (cmd_valid === 1'b1) begin
        chk("cmd_data", cmd_data, src ? {52'h0, a[11:0]} : {40'h0, a});
        n++;
        idle = 0;
      end else idle++;
    end
  endtask
  task t_reset;
    for (int i = 0; i < 4; i++) rd(5'(i * 4), 32'h0);
    $display("reset values done");
  endtask
  task t_fetch;
    wb(1'b1, 5'h00, 32'h100);
    wb(1'b1, 5'h04, 32'h100);
    drain(24'h100);
    chk("idle count", n, 0);
    wb(1'b1, 5'h04, 32'h118);
    drain(24'h100);
    chk("word count", n, 3);
    rd(5'h08, 32'h118);
    $display("dram fetch done");
  endtask
  task t_pend;
    @(posedge clk);
    cmd_ready <= 1'b0;
    wb(1'b1, 5'h04, 32'h158);
    repeat (80) @(posedge clk);
    rd(5'h0c, 32'h100);
    wb(1'b1, 5'h00, 32'h400);
    wb(1'b1, 5'h04, 32'h400);
    rd(5'h0c, 32'h700);
    drain(24'h118);
    chk("old words whole", n > 4 && n < 8, 1);
    rd(5'h08, 32'h400);
    rd(5'h0c, 32'h0);
    $display("pending pointers done");
  endtask
  task t_sp_data_memory;
    wb(1'b1, 5'h0c, 32'h2);
    rd(5'h0c, 32'h1);
    src = 1'b1;
    wb(1'b1, 5'h00, 32'h1000);
    wb(1'b1, 5'h04, 32'h1000);
    wb(1'b1, 5'h04, 32'h1010);
    drain(24'h1000);
    chk("memory words", n, 2);
    wb(1'b1, 5'h08, 32'h55);
    rd(5'h08, 32'h1010);
    rd(5'h10, 32'h0);
    wb(1'b1, 5'h0c, 32'h1);
    src = 1'b0;
    rd(5'h0c, 32'h0);
    $display("data memory done");
  endtask
  task t_wrap;
    wb(1'b1, 5'h04, 32'h1028);
    do wb(1'b0, 5'h0c, 32'h0); while (rdata[10]);
    do wb(1'b0, 5'h08, 32'h0); while (rdata == 32'h1010);
    wb(1'b1, 5'h00, 32'h1010);
    wb(1'b0, 5'h0c, 32'h0);
    chk("start flag", rdata[10:9], 2'b10);
    do wb(1'b0, 5'h08, 32'h0); while (rdata >= 32'h1010 && rdata <= 32'h1020);
    chk("region done", rdata, 32'h1028);
    wb(1'b1, 5'h04, 32'h1020);
    drain(24'h1010);
    chk("wrap words", n, 2);
    rd(5'h08, 32'h1020);
    rd(5'h0c, 32'h0);
    $display("ring wrap done");
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_reset;
    t_fetch;
    t_pend;
    t_sp_data_memory;
    t_wrap;
    results;
  end
endmodule // test_display_command_fetch
